/* File: hw/adcsq_params.svh */
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// register byte offsets on the apb port
`define ADCSQ_OFF_CTRL    12'h000
`define ADCSQ_OFF_CFG     12'h004
`define ADCSQ_OFF_STAT    12'h008
`define ADCSQ_OFF_MASK    12'h00c
`define ADCSQ_OFF_RESULT  12'h010

// adc_control_one field positions
`define ADCSQ_B_DONE      0
`define ADCSQ_B_SAMPLE_ENABLE      1
`define ADCSQ_B_AUTO_SAMPLE_START      2
`define ADCSQ_B_SIMULTANEOUS_SAMPLE_SELECT    3
`define ADCSQ_B_UNIMP     4
`define ADCSQ_B_CONVERSION_TRIGGER_SOURCE_LO   5
`define ADCSQ_B_CONVERSION_TRIGGER_SOURCE_HI   7
`define ADCSQ_B_OUTPUT_FORMAT_SELECT_LO   8
`define ADCSQ_B_OUTPUT_FORMAT_SELECT_HI   9
`define ADCSQ_B_TWELVE_BIT_RESOLUTION_SELECT     10

// config register fields: channel count and auto-convert sample time
`define ADCSQ_B_CHANNEL_COUNT_SELECT_LO   0
`define ADCSQ_B_CHANNEL_COUNT_SELECT_HI   1
`define ADCSQ_B_SAMT_LO   8
`define ADCSQ_B_SAMT_HI   12
`define ADCSQ_SAMT_RST    5'h03

// interrupt status and mask bits
`define ADCSQ_EV_DONE     0
`define ADCSQ_EV_START    1

// conversion trigger source codes
`define ADCSQ_CONVERSION_TRIGGER_SOURCE_MANUAL 3'h0
`define ADCSQ_CONVERSION_TRIGGER_SOURCE_EXT    3'h1
`define ADCSQ_CONVERSION_TRIGGER_SOURCE_TMR_A  3'h2
`define ADCSQ_CONVERSION_TRIGGER_SOURCE_TMR_B  3'h4
`define ADCSQ_CONVERSION_TRIGGER_SOURCE_AUTO   3'h7

`endif

/* File: hw/adcsq_pkg.sv */
package adcsq_pkg;

  // sample/hold sequencer states
  typedef enum logic [1:0] {
    S_HOLD    = 2'b00,
    S_SAMPLE  = 2'b01,
    S_CONVERT = 2'b10
  } adcsq_state_e;

  // whole state of the sequencer top
  typedef struct packed {
    adcsq_state_e state;
    logic         twelve_bit_resolution_select;
    logic [1:0]   output_format_select;
    logic [2:0]   conversion_trigger_source;
    logic         simultaneous_sample_select;
    logic         auto_sample_start;
    logic         done;
    logic [1:0]   channel_count_select;
    logic [4:0]   samt;
    logic [1:0]   stat;
    logic [1:0]   mask;
    logic [1:0]   ch;
    logic [4:0]   cnt;
    logic [3:0]   sh;
    logic         conv_start;
    logic [1:0]   conv_chan;
    logic         irq;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } adcsq_regs_s;

  // whole state of the result formatter
  typedef struct packed {
    logic [15:0] result;
  } adcsq_fmt_s;

endpackage

/* File: hw/adcsq_fmt.sv */
`include "adcsq_params.svh"

module adcsq_fmt #(
  parameter int DATA_W = 12
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // raw result in
  input  wire logic              load_in,
  input  wire logic              twelve_in,
  input  wire logic [1:0]        fmt_in,
  input  wire logic [DATA_W-1:0] data_in,
  // formatted result out
  output logic      [15:0]       result_out
);

  adcsq_pkg::adcsq_fmt_s q;
  adcsq_pkg::adcsq_fmt_s d;

  // refused at elaboration: the layouts assume a 12-bit word
  if (DATA_W != 12) begin
    $error("adcsq_fmt serves a 12-bit converter only");
  end

  // signed forms use the inverted top data bit as sign
  function automatic logic [15:0] format_fn(input logic twelve, input logic [1:0] fmt, input logic [11:0] raw);
    logic s10;
    logic s12;
    s10 = ~raw[9];
    s12 = ~raw[11];
    if (twelve) begin
      case (fmt)
        2'h0:    format_fn = {4'h0, raw};
        2'h1:    format_fn = {{4{s12}}, s12, raw[10:0]};
        2'h2:    format_fn = {raw, 4'h0};
        default: format_fn = {s12, raw[10:0], 4'h0};
      endcase
    end else begin
      case (fmt)
        2'h0:    format_fn = {6'h00, raw[9:0]};
        2'h1:    format_fn = {{6{s10}}, s10, raw[8:0]};
        2'h2:    format_fn = {raw[9:0], 6'h00};
        default: format_fn = {s10, raw[8:0], 6'h00};
      endcase
    end
  endfunction

  // latch the layout chosen at the moment the word arrives
  always_comb begin
    d = q;
    if (load_in) begin
      d.result = format_fn(twelve_in, fmt_in, data_in);
    end
    if (!rst_n_in) begin
      d = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    q <= d;
  end

  assign result_out = q.result;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_fmt_signed12;
    (load_in && twelve_in && fmt_in == 2'h1) |=> (result_out[15:11] == {5{~$past(data_in[11])}});
  endproperty
  a_fmt_signed12: assert property (p_fmt_signed12) else $error("signed 12-bit result badly extended");

endmodule

/* File: hw/adcsq_seq.sv */
`include "adcsq_params.svh"

module adcsq_seq #(
  parameter int NUM_CH = 4,
  parameter int DATA_W = 12
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // hardware trigger sources
  input  wire logic              ext_trig_in,
  input  wire logic              timer_a_match_in,
  input  wire logic              timer_b_match_in,
  // conversion core
  input  wire logic              conv_done_in,
  input  wire logic [DATA_W-1:0] conv_data_in,
  output logic      [3:0]        sh_sample_out,
  output logic                   conv_start_out,
  output logic      [1:0]        conv_chan_out,
  // interrupt
  output logic                   irq_out
);

  adcsq_pkg::adcsq_regs_s q;
  adcsq_pkg::adcsq_regs_s d;
  logic [15:0]            result;
  logic                   acc;
  logic                   wr_ctrl;
  logic                   rd_stat;
  logic                   simultaneous_sample_select_eff;
  logic                   trig;
  logic                   last;
  logic                   sw_sample_enable_set;
  logic                   sw_sample_enable_clr;
  logic                   seq_end;

  // refused at elaboration: only four sample/hold channels are wired
  if (NUM_CH != 4) begin
    $error("adcsq_seq drives exactly four sample/hold channels");
  end

  // index of the last channel in a sequence
  function automatic logic [1:0] last_ch_fn(input logic [1:0] channel_count_select);
    if (channel_count_select[1]) begin
      last_ch_fn = 2'h3;
    end else begin
      last_ch_fn = {1'b0, channel_count_select[0]};
    end
  endfunction

  // which sample/hold amplifiers acquire
  function automatic logic [3:0] sample_mask_fn(input logic sim, input logic [1:0] channel_count_select, input logic [1:0] ch);
    if (sim && channel_count_select[1]) begin
      sample_mask_fn = 4'hf;
    end else if (sim && channel_count_select[0]) begin
      sample_mask_fn = 4'h3;
    end else begin
      sample_mask_fn = 4'h1 << ch;
    end
  endfunction

  // control word as software sees it
  function automatic logic [15:0] ctrl_word_fn(input adcsq_pkg::adcsq_regs_s r);
    ctrl_word_fn = 16'h0000;
    ctrl_word_fn[`ADCSQ_B_TWELVE_BIT_RESOLUTION_SELECT] = r.twelve_bit_resolution_select;
    ctrl_word_fn[`ADCSQ_B_OUTPUT_FORMAT_SELECT_HI:`ADCSQ_B_OUTPUT_FORMAT_SELECT_LO] = r.output_format_select;
    ctrl_word_fn[`ADCSQ_B_CONVERSION_TRIGGER_SOURCE_HI:`ADCSQ_B_CONVERSION_TRIGGER_SOURCE_LO] = r.conversion_trigger_source;
    ctrl_word_fn[`ADCSQ_B_SIMULTANEOUS_SAMPLE_SELECT] = r.simultaneous_sample_select & ~r.twelve_bit_resolution_select;
    ctrl_word_fn[`ADCSQ_B_AUTO_SAMPLE_START] = r.auto_sample_start;
    ctrl_word_fn[`ADCSQ_B_SAMPLE_ENABLE] = (r.state == adcsq_pkg::S_SAMPLE);
    ctrl_word_fn[`ADCSQ_B_DONE] = r.done;
  endfunction

  // bus strobes and sequencer conditions
  always_comb begin
    acc         = psel_in & penable_in & q.pready;
    wr_ctrl     = acc & pwrite_in & (paddr_in == `ADCSQ_OFF_CTRL);
    rd_stat     = acc & ~pwrite_in & (paddr_in == `ADCSQ_OFF_STAT);
    simultaneous_sample_select_eff  = q.simultaneous_sample_select & ~q.twelve_bit_resolution_select;
    last        = (q.ch == last_ch_fn(q.channel_count_select));
    sw_sample_enable_set = wr_ctrl & pwdata_in[`ADCSQ_B_SAMPLE_ENABLE] & ~q.auto_sample_start;
    sw_sample_enable_clr = wr_ctrl & ~pwdata_in[`ADCSQ_B_SAMPLE_ENABLE] & (q.conversion_trigger_source == `ADCSQ_CONVERSION_TRIGGER_SOURCE_MANUAL);
    seq_end     = (q.state == adcsq_pkg::S_CONVERT) & conv_done_in & last;
    // reserved codes select nothing, so sampling waits for a code change
    case (q.conversion_trigger_source)
      `ADCSQ_CONVERSION_TRIGGER_SOURCE_EXT:   trig = ext_trig_in;
      `ADCSQ_CONVERSION_TRIGGER_SOURCE_TMR_A: trig = timer_a_match_in;
      `ADCSQ_CONVERSION_TRIGGER_SOURCE_TMR_B: trig = timer_b_match_in;
      `ADCSQ_CONVERSION_TRIGGER_SOURCE_AUTO:  trig = (q.cnt == 5'h00);
      default:           trig = 1'b0;
    endcase
  end

  // next state of registers, sequencer and bus answer
  always_comb begin
    d            = q;
    d.conv_start = 1'b0;
    // no wait state: pready rises in the first access cycle
    d.pready     = psel_in & ~penable_in;
    // software writes; the done flag can only be cleared
    if (wr_ctrl) begin
      d.twelve_bit_resolution_select = pwdata_in[`ADCSQ_B_TWELVE_BIT_RESOLUTION_SELECT];
      d.output_format_select  = pwdata_in[`ADCSQ_B_OUTPUT_FORMAT_SELECT_HI:`ADCSQ_B_OUTPUT_FORMAT_SELECT_LO];
      d.conversion_trigger_source  = pwdata_in[`ADCSQ_B_CONVERSION_TRIGGER_SOURCE_HI:`ADCSQ_B_CONVERSION_TRIGGER_SOURCE_LO];
      d.auto_sample_start  = pwdata_in[`ADCSQ_B_AUTO_SAMPLE_START];
      if (!q.twelve_bit_resolution_select) begin
        d.simultaneous_sample_select = pwdata_in[`ADCSQ_B_SIMULTANEOUS_SAMPLE_SELECT];
      end
      if (!pwdata_in[`ADCSQ_B_DONE]) begin
        d.done = 1'b0;
      end
    end
    if (acc && pwrite_in && paddr_in == `ADCSQ_OFF_CFG) begin
      d.channel_count_select = pwdata_in[`ADCSQ_B_CHANNEL_COUNT_SELECT_HI:`ADCSQ_B_CHANNEL_COUNT_SELECT_LO];
      d.samt = pwdata_in[`ADCSQ_B_SAMT_HI:`ADCSQ_B_SAMT_LO];
    end
    if (acc && pwrite_in && paddr_in == `ADCSQ_OFF_MASK) begin
      d.mask = pwdata_in[1:0];
    end
    // read clears only the bits that were reported, so a late event survives
    if (rd_stat) begin
      d.stat = q.stat & ~q.prdata[1:0];
    end
    // sequencer; a clear of done never touches the state
    case (q.state)
      adcsq_pkg::S_HOLD: begin
        if (sw_sample_enable_set || q.auto_sample_start) begin
          d.state = adcsq_pkg::S_SAMPLE;
          d.ch    = 2'h0;
          d.cnt   = q.samt;
        end
      end
      adcsq_pkg::S_SAMPLE: begin
        if (q.cnt != 5'h00) begin
          d.cnt = q.cnt - 5'h01;
        end
        if (sw_sample_enable_clr || (q.conversion_trigger_source != `ADCSQ_CONVERSION_TRIGGER_SOURCE_MANUAL && trig)) begin
          d.state      = adcsq_pkg::S_CONVERT;
          d.conv_start = 1'b1;
          d.conv_chan  = q.ch;
          d.done       = 1'b0;
          d.stat[`ADCSQ_EV_START] = 1'b1;
        end
      end
      adcsq_pkg::S_CONVERT: begin
        if (conv_done_in && !last) begin
          d.ch = q.ch + 2'h1;
          if (simultaneous_sample_select_eff) begin
            // held values convert one after another
            d.conv_start = 1'b1;
            d.conv_chan  = q.ch + 2'h1;
          end else begin
            d.state = adcsq_pkg::S_SAMPLE;
            d.cnt   = q.samt;
          end
        end else if (seq_end) begin
          d.done = 1'b1;
          d.stat[`ADCSQ_EV_DONE] = 1'b1;
          d.ch   = 2'h0;
          d.cnt  = q.samt;
          d.state = q.auto_sample_start ? adcsq_pkg::S_SAMPLE : adcsq_pkg::S_HOLD;
        end
      end
      default: d.state = adcsq_pkg::S_HOLD;
    endcase
    // next mode bits, so a write that starts sampling is honoured at once
    if (d.state == adcsq_pkg::S_SAMPLE) begin
      d.sh = sample_mask_fn(d.simultaneous_sample_select & ~d.twelve_bit_resolution_select, d.channel_count_select, d.ch);
    end else begin
      d.sh = 4'h0;
    end
    d.irq = |(d.stat & d.mask);
    // read data and error answer prepared in the setup cycle
    d.prdata  = 32'h0000_0000;
    d.pslverr = 1'b0;
    if (psel_in && !penable_in) begin
      if (paddr_in == `ADCSQ_OFF_CTRL) begin
        d.prdata[15:0] = ctrl_word_fn(q);
      end else if (paddr_in == `ADCSQ_OFF_CFG) begin
        d.prdata[`ADCSQ_B_CHANNEL_COUNT_SELECT_HI:`ADCSQ_B_CHANNEL_COUNT_SELECT_LO] = q.channel_count_select;
        d.prdata[`ADCSQ_B_SAMT_HI:`ADCSQ_B_SAMT_LO] = q.samt;
      end else if (paddr_in == `ADCSQ_OFF_STAT) begin
        d.prdata[1:0] = q.stat;
      end else if (paddr_in == `ADCSQ_OFF_MASK) begin
        d.prdata[1:0] = q.mask;
      end else if (paddr_in == `ADCSQ_OFF_RESULT) begin
        d.prdata[15:0] = result;
      end else begin
        d.pslverr = 1'b1;
      end
    end
    if (!rst_n_in) begin
      d      = '0;
      d.samt = `ADCSQ_SAMT_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    q <= d;
  end

  // result layout applied as each word lands
  adcsq_fmt #(
    .DATA_W (DATA_W)
  ) u_fmt (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (q.state == adcsq_pkg::S_CONVERT && conv_done_in),
    .twelve_in   (q.twelve_bit_resolution_select),
    .fmt_in      (q.output_format_select),
    .data_in     (conv_data_in),
    .result_out  (result)
  );

  assign prdata_out     = q.prdata;
  assign pready_out     = q.pready;
  assign pslverr_out    = q.pslverr;
  assign sh_sample_out  = q.sh;
  assign conv_start_out = q.conv_start;
  assign conv_chan_out  = q.conv_chan;
  assign irq_out        = q.irq;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_simultaneous_sample_select_12b;
    (psel_in && !penable_in && paddr_in == `ADCSQ_OFF_CTRL && q.twelve_bit_resolution_select) |=> !prdata_out[`ADCSQ_B_SIMULTANEOUS_SAMPLE_SELECT];
  endproperty
  a_simultaneous_sample_select_12b: assert property (p_simultaneous_sample_select_12b) else $error("simultaneous bit visible in 12-bit mode");

  property p_sim_four;
    (q.state == adcsq_pkg::S_SAMPLE && simultaneous_sample_select_eff && q.channel_count_select[1] && $stable(q.channel_count_select)) |-> sh_sample_out == 4'hf;
  endproperty
  a_sim_four: assert property (p_sim_four) else $error("four channels not sampled together");

  property p_sim_two;
    (q.state == adcsq_pkg::S_SAMPLE && simultaneous_sample_select_eff && q.channel_count_select == 2'h1 && $stable(q.channel_count_select)) |-> sh_sample_out == 4'h3;
  endproperty
  a_sim_two: assert property (p_sim_two) else $error("channels zero and one not sampled together");

  property p_seq_one;
    (q.state == adcsq_pkg::S_SAMPLE && !simultaneous_sample_select_eff) |-> sh_sample_out == (4'h1 << q.ch);
  endproperty
  a_seq_one: assert property (p_seq_one) else $error("sequential mode sampled more than one channel");

  property p_auto_restart;
    (seq_end && q.auto_sample_start) |=> (q.state == adcsq_pkg::S_SAMPLE) && (sh_sample_out != 4'h0);
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto-start did not resume sampling");

  property p_no_self_start;
    (q.state == adcsq_pkg::S_HOLD && !q.auto_sample_start && !sw_sample_enable_set) |=> q.state == adcsq_pkg::S_HOLD;
  endproperty
  a_no_self_start: assert property (p_no_self_start) else $error("sampling began without software");

  property p_sample_enable_reads;
    (psel_in && !penable_in && paddr_in == `ADCSQ_OFF_CTRL) |=> prdata_out[`ADCSQ_B_SAMPLE_ENABLE] == $past(sh_sample_out != 4'h0);
  endproperty
  a_sample_enable_reads: assert property (p_sample_enable_reads) else $error("sample enable read disagrees with amplifiers");

  property p_manual_waits;
    (q.state == adcsq_pkg::S_SAMPLE && q.conversion_trigger_source == `ADCSQ_CONVERSION_TRIGGER_SOURCE_MANUAL && !sw_sample_enable_clr) |=> !conv_start_out;
  endproperty
  a_manual_waits: assert property (p_manual_waits) else $error("manual mode converted without software");

  property p_hw_trigger;
    (q.state == adcsq_pkg::S_SAMPLE && q.conversion_trigger_source != `ADCSQ_CONVERSION_TRIGGER_SOURCE_MANUAL && trig) |=> conv_start_out ##1 !conv_start_out;
  endproperty
  a_hw_trigger: assert property (p_hw_trigger) else $error("selected trigger did not start one conversion");

  property p_done_sets;
    seq_end |=> q.done;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done not set at end of conversion");

  property p_clear_keeps;
    (q.state == adcsq_pkg::S_CONVERT && wr_ctrl && !conv_done_in) |=> q.state == adcsq_pkg::S_CONVERT;
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("clearing done disturbed a conversion");

  property p_done_clear_start;
    conv_start_out && $past(q.state == adcsq_pkg::S_SAMPLE) |-> !q.done;
  endproperty
  a_done_clear_start: assert property (p_done_clear_start) else $error("done still set as conversion begins");

  property p_bit4_zero;
    (psel_in && !penable_in && paddr_in == `ADCSQ_OFF_CTRL) |=> !prdata_out[`ADCSQ_B_UNIMP];
  endproperty
  a_bit4_zero: assert property (p_bit4_zero) else $error("unimplemented control bit read as 1");

  property p_reserved_idle;
    (q.state == adcsq_pkg::S_SAMPLE && (q.conversion_trigger_source == 3'h3 || q.conversion_trigger_source == 3'h5 || q.conversion_trigger_source == 3'h6) && !wr_ctrl)
      |=> q.state == adcsq_pkg::S_SAMPLE;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle) else $error("reserved trigger code ended sampling");

endmodule

/* File: test/adcsq_core_model.sv */
module adcsq_core_model (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // conversion request and latency
  input  wire logic        conv_start_in,
  input  wire logic [1:0]  conv_chan_in,
  input  wire logic [7:0]  lat_in,
  // conversion answer
  output logic             conv_done_out,
  output logic      [11:0] conv_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_q;
  logic [1:0] chan_q;

  // one conversion at a time; data scrambles outside the done pulse
  always @(posedge core_clk_in) begin
    conv_done_out <= 1'b0;
    conv_data_out <= ~conv_data_out;
    if (!rst_n_in) begin
      cnt_q <= 8'h00;
      conv_data_out <= 12'h000;
    end else if (conv_start_in) begin
      cnt_q <= lat_in;
      chan_q <= conv_chan_in;
    end else if (cnt_q == 8'h01) begin
      cnt_q <= 8'h00;
      conv_done_out <= 1'b1;
      conv_data_out <= {2'h2, chan_q, 8'h5a}; // top bit set so signed forms show
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

/* File: test/tb_adc_sample_convert_sequencer.sv */
`include "adcsq_params.svh"

module tb_adc_sample_convert_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] A_CTL = `ADCSQ_OFF_CTRL;
  localparam logic [11:0] A_CFG = `ADCSQ_OFF_CFG;
  localparam logic [11:0] A_ST  = `ADCSQ_OFF_STAT;
  localparam logic [11:0] A_MSK = `ADCSQ_OFF_MASK;
  localparam logic [11:0] A_RES = `ADCSQ_OFF_RESULT;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [2:0]  trg = 3'h0;
  logic [7:0]  lat = 8'h14;
  logic        cdone;
  logic [11:0] cdata;
  logic [3:0]  sh;
  logic        cst;
  logic [1:0]  cch;
  logic        irq;
  int          num_errors = 0;
  int          comparisons = 0;

  // 25 mhz core clock
  always #20 clk = ~clk;

  adcsq_seq i_adcsq_seq (
    .core_clk_in      (clk),
    .rst_n_in         (rst_n),
    .psel_in          (psel),
    .penable_in       (penable),
    .pwrite_in        (pwrite),
    .paddr_in         (paddr),
    .pwdata_in        (pwdata),
    .prdata_out       (prdata),
    .pready_out       (pready),
    .pslverr_out      (pslverr),
    .ext_trig_in      (trg[0]),
    .timer_a_match_in (trg[1]),
    .timer_b_match_in (trg[2]),
    .conv_done_in     (cdone),
    .conv_data_in     (cdata),
    .sh_sample_out    (sh),
    .conv_start_out   (cst),
    .conv_chan_out    (cch),
    .irq_out          (irq)
  );

  adcsq_core_model i_adcsq_core_model (
    .core_clk_in   (clk),
    .rst_n_in      (rst_n),
    .conv_start_in (cst),
    .conv_chan_in  (cch),
    .lat_in        (lat),
    .conv_done_out (cdone),
    .conv_data_out (cdata)
  );

  task automatic finish_test;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // poll the done bit of the control word instead of assuming a conversion length
  task automatic poll_done;
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0;
    while (r[0] !== 1'b1 && n < 60) begin
      apb(1'b0, A_CTL, 32'h0, r);
      n++;
    end
    chk(32'(r[0]), 32'h1);
  endtask

  task automatic wait_sh(input logic [3:0] v);
    int n;
    n = 0;
    while (sh !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(32'(sh), 32'(v));
  endtask

  task automatic wait_start(input logic [1:0] ch);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cst !== 1'b1 && n < 200);
    chk(32'({cst, cch}), 32'({1'b1, ch}));
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    trg <= m;
    @(posedge clk);
    trg <= 3'h0;
  endtask

  task automatic t_reset;
    logic [31:0] r;
    repeat (10) @(posedge clk);
    chk(32'({sh, cst, irq}), 32'h0);
    rd(A_CTL, 32'h0);
    rd(A_CFG, 32'h300);
    apb(1'b0, 12'h020, 32'h0, r);
    chk(32'(last_err), 32'h1);
    chk(r, 32'h0);
    wr(A_CTL, 32'h10);
    rd(A_CTL, 32'h0);
  endtask

  task automatic t_manual;
    wr(A_CTL, 32'h2);
    wait_sh(4'h1);
    rd(A_CTL, 32'h2);
    repeat (10) @(posedge clk);
    chk(32'(sh), 32'h1);
    wr(A_CTL, 32'h0);
    wait_start(2'h0);
    chk(32'(sh), 32'h0);
    rd(A_CTL, 32'h0);
    poll_done();
    wr(A_CTL, 32'h3);
    wr(A_CTL, 32'h1);
    rd(A_CTL, 32'h0);
    wr(A_CTL, 32'h0);
    poll_done();
    wr(A_CTL, 32'h0);
    rd(A_CTL, 32'h0);
  endtask

  // each hardware source ends sampling; the other sources must not
  task automatic t_trig;
    logic [2:0] code [3] = '{3'h1, 3'h2, 3'h4};
    logic [2:0] bad [3] = '{3'h3, 3'h5, 3'h6};
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, {24'h0, code[i], 5'h02});
      wait_sh(4'h1);
      pulse(~code[i]);
      repeat (3) @(posedge clk);
      chk(32'(sh), 32'h1);
      pulse(code[i]);
      wait_start(2'h0);
      poll_done();
    end
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, {24'h0, bad[i], 5'h02});
      wait_sh(4'h1);
      pulse(3'h7);
      repeat (3) @(posedge clk);
      chk(32'(sh), 32'h1);
    end
    // software end of sampling needs the manual code already in place
    wr(A_CTL, 32'h2);
    wr(A_CTL, 32'h0);
    poll_done();
    wr(A_CTL, 32'he2);
    wait_start(2'h0);
    poll_done();
  endtask

  task automatic t_auto;
    lat <= 8'h02;
    wr(A_CTL, 32'he4);
    wait_start(2'h0);
    wait_sh(4'h1);
    wait_start(2'h0);
    wr(A_CTL, 32'he0);
    wait_sh(4'h0);
    repeat (20) @(posedge clk);
    chk(32'(sh), 32'h0);
  endtask

  task automatic t_sim;
    lat <= 8'h03;
    wr(A_CFG, 32'h302);
    wr(A_CTL, 32'ha);
    wait_sh(4'hf);
    wr(A_CTL, 32'h8);
    for (int c = 0; c < 4; c++) begin
      wait_start(2'(c));
    end
    poll_done();
    wr(A_CFG, 32'h301);
    wr(A_CTL, 32'ha);
    wait_sh(4'h3);
    wr(A_CTL, 32'h8);
    wait_start(2'h0);
    wait_start(2'h1);
    poll_done();
    wr(A_CFG, 32'h302);
    wr(A_CTL, 32'he2);
    for (int c = 0; c < 4; c++) begin
      wait_sh(4'(1 << c));
      wait_start(2'(c));
    end
    poll_done();
    wr(A_CFG, 32'h300);
  endtask

  task automatic t_twelve;
    wr(A_CTL, 32'h400);
    wr(A_CTL, 32'h408);
    rd(A_CTL, 32'h400);
    wr(A_CTL, 32'h0);
    rd(A_CTL, 32'h0);
    wr(A_CTL, 32'h8);
    rd(A_CTL, 32'h8);
    wr(A_CTL, 32'h0);
  endtask

  // interrupt raised, cleared by a status read, then masked off
  task automatic t_irq;
    logic [31:0] r;
    apb(1'b0, A_ST, 32'h0, r);
    wr(A_MSK, 32'h1);
    wr(A_CTL, 32'h402);
    wr(A_CTL, 32'h400);
    poll_done();
    chk(32'(irq), 32'h1);
    rd(A_RES, 32'h85a);
    rd(A_ST, 32'h3);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(A_MSK, 32'h0);
    wr(A_CTL, 32'h502);
    wr(A_CTL, 32'h500);
    poll_done();
    chk(32'(irq), 32'h0);
    rd(A_RES, 32'h5a);
    rd(A_ST, 32'h3);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_manual();
    t_trig();
    t_auto();
    t_sim();
    t_twelve();
    t_irq();
    finish_test();
  end

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
